// ===== icc_defines.svh
// register offsets, field positions and reset values of the bus control block
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH
`define ICC_OFS_CTRL          32'h5000_1300
`define ICC_OFS_STD_HIGH      32'h5000_1314
`define ICC_OFS_STD_LOW       32'h5000_1318
`define ICC_OFS_FAST_HIGH     32'h5000_131c
`define ICC_OFS_FAST_LOW      32'h5000_1320
`define ICC_OFS_CFG_STATUS    32'h5000_13f0
`define ICC_BIT_INIT_EN       0
`define ICC_BIT_RATE_LO       1
`define ICC_BIT_RATE_HI       2
`define ICC_BIT_RESP_WIDE     3
`define ICC_BIT_INIT_WIDE     4
`define ICC_BIT_RESTART_EN    5
`define ICC_BIT_RESP_DIS      6
`define ICC_CTRL_RESET        16'h007d
`define ICC_CTRL_MASK         16'h007f
`define ICC_STD_HIGH_RESET    16'h00c8
`define ICC_STD_LOW_RESET     16'h00d0
`define ICC_FAST_HIGH_RESET   16'h0030
`define ICC_FAST_LOW_RESET    16'h0040
`endif

// ===== icc_pkg.sv
// types shared by the bus control block
package icc_pkg;
   // bus rate codes of the two-bit rate field
   typedef enum logic [1:0] {
      ICC_RATE_STD  = 2'h1,
      ICC_RATE_FAST = 2'h2
   } icc_rate_t;
endpackage

// ===== icc_ctrl.sv
// apb control and clock-count registers of the two-wire bus controller
//
// Contract
// - bit 6 disables responder, resets to one
// - bit 5 permits repeated starts, resets one
// - bit 4 selects initiator 10-bit addressing
// - bit 3 selects responder 10-bit addressing
// - bits 2:1 select rate, reset two
// - bit 0 enables initiator, resets one
// - count resets assume 4.3 kilohm pull-ups
`timescale 1ns/1ps
`include "icc_defines.svh"
module icc_ctrl #(
   parameter logic [15:0] STD_HIGH_RESET  = `ICC_STD_HIGH_RESET,
   parameter logic [15:0] STD_LOW_RESET   = `ICC_STD_LOW_RESET,
   parameter logic [15:0] FAST_HIGH_RESET = `ICC_FAST_HIGH_RESET,
   parameter logic [15:0] FAST_LOW_RESET  = `ICC_FAST_LOW_RESET
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             initiator_en,
   output logic             responder_en,
   output logic             restart_allowed,
   output logic             initiator_wide_addr,
   output logic             responder_wide_addr,
   output logic             rate_fast,
   output logic      [15:0] clk_high_count,
   output logic      [15:0] clk_low_count
);

   // register file
   logic [15:0] bus_control_config;   // control word, low 7 bits live
   logic [15:0] std_clk_high_count;   // standard rate high period
   logic [15:0] std_clk_low_count;    // standard rate low period
   logic [15:0] fast_clk_high_count;  // fast rate high period
   logic [15:0] fast_clk_low_count;   // fast rate low period
   logic [15:0] next_ctrl;
   logic [15:0] next_std_high;
   logic [15:0] next_std_low;
   logic [15:0] next_fast_high;
   logic [15:0] next_fast_low;
   // bus answer
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   // role and timing outputs
   logic        next_init_en;
   logic        next_resp_en;
   logic        next_restart;
   logic        next_init_wide;
   logic        next_resp_wide;
   logic        next_rate_fast;
   logic [15:0] next_high;
   logic [15:0] next_low;
   logic        access;            // access phase, not yet answered
   logic        hit;               // address maps to a register
   logic        wr;                // write takes effect this edge
   logic [15:0] rd_word;           // read mux result
   logic        rate_legal;        // rate field holds a defined code

   // decode of a byte address into a register hit
   function automatic logic addr_hit(input logic [31:0] a);
      addr_hit = (a == `ICC_OFS_CTRL) || (a == `ICC_OFS_STD_HIGH) ||
                 (a == `ICC_OFS_STD_LOW) || (a == `ICC_OFS_FAST_HIGH) ||
                 (a == `ICC_OFS_FAST_LOW) || (a == `ICC_OFS_CFG_STATUS);
   endfunction

   // one wait state: answer comes on the second access cycle
   assign access = psel && penable && !pready;
   assign hit    = addr_hit(paddr);
   // write lands at the edge where the master samples pready high, never earlier;
   // limitation: the master must not close a transfer while clk_en is low
   assign wr     = psel && penable && pready && pwrite && hit;
   // only codes 1 and 2 name a rate; the status word flags the others
   assign rate_legal =
      (bus_control_config[`ICC_BIT_RATE_HI:`ICC_BIT_RATE_LO] == icc_pkg::ICC_RATE_STD) ||
      (bus_control_config[`ICC_BIT_RATE_HI:`ICC_BIT_RATE_LO] == icc_pkg::ICC_RATE_FAST);

   // next register values
   always_comb begin
      next_ctrl      = bus_control_config;
      next_std_high  = std_clk_high_count;
      next_std_low   = std_clk_low_count;
      next_fast_high = fast_clk_high_count;
      next_fast_low  = fast_clk_low_count;
      if (wr) begin
         case (paddr)
            // reserved upper bits are dropped by the mask
            `ICC_OFS_CTRL:      next_ctrl = pwdata[15:0] & `ICC_CTRL_MASK;
            `ICC_OFS_STD_HIGH:  next_std_high = pwdata[15:0];
            `ICC_OFS_STD_LOW:   next_std_low = pwdata[15:0];
            `ICC_OFS_FAST_HIGH: next_fast_high = pwdata[15:0];
            `ICC_OFS_FAST_LOW:  next_fast_low = pwdata[15:0];
            default:            next_ctrl = bus_control_config;  // status is read only
         endcase
      end
   end

   // read mux and answer
   always_comb begin
      rd_word = 16'h0000;
      case (paddr)
         `ICC_OFS_CTRL:       rd_word = bus_control_config & `ICC_CTRL_MASK;
         `ICC_OFS_STD_HIGH:   rd_word = std_clk_high_count;
         `ICC_OFS_STD_LOW:    rd_word = std_clk_low_count;
         `ICC_OFS_FAST_HIGH:  rd_word = fast_clk_high_count;
         `ICC_OFS_FAST_LOW:   rd_word = fast_clk_low_count;
         // live state: both roles on, rate code legal
         `ICC_OFS_CFG_STATUS: rd_word = {14'h0, rate_legal, (initiator_en && responder_en)};
         default:             rd_word = 16'h0000;
      endcase
      next_pready  = access;
      next_pslverr = access && !hit;
      next_prdata  = (access && !pwrite && hit) ? {16'h0000, rd_word} : 32'h0000_0000;
   end

   // role and timing decode from the control word
   always_comb begin
      next_init_en   = bus_control_config[`ICC_BIT_INIT_EN];
      next_resp_en   = !bus_control_config[`ICC_BIT_RESP_DIS];
      next_restart   = bus_control_config[`ICC_BIT_RESTART_EN];
      next_init_wide = bus_control_config[`ICC_BIT_INIT_WIDE];
      next_resp_wide = bus_control_config[`ICC_BIT_RESP_WIDE];
      // unused codes 0 and 3 fall back to fast, the reset rate
      next_rate_fast = (bus_control_config[`ICC_BIT_RATE_HI:`ICC_BIT_RATE_LO] !=
                        icc_pkg::ICC_RATE_STD);
      next_high      = next_rate_fast ? fast_clk_high_count : std_clk_high_count;
      next_low       = next_rate_fast ? fast_clk_low_count : std_clk_low_count;
   end

   // registers, frozen while clk_en is low
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_control_config  <= `ICC_CTRL_RESET;
         std_clk_high_count  <= STD_HIGH_RESET;
         std_clk_low_count   <= STD_LOW_RESET;
         fast_clk_high_count <= FAST_HIGH_RESET;
         fast_clk_low_count  <= FAST_LOW_RESET;
         prdata              <= 32'h0000_0000;
         pready              <= 1'b0;
         pslverr             <= 1'b0;
         initiator_en        <= 1'b1;
         responder_en        <= 1'b0;
         restart_allowed     <= 1'b1;
         initiator_wide_addr <= 1'b1;
         responder_wide_addr <= 1'b1;
         rate_fast           <= 1'b1;
         clk_high_count      <= FAST_HIGH_RESET;
         clk_low_count       <= FAST_LOW_RESET;
      end else if (clk_en) begin
         bus_control_config  <= next_ctrl;
         std_clk_high_count  <= next_std_high;
         std_clk_low_count   <= next_std_low;
         fast_clk_high_count <= next_fast_high;
         fast_clk_low_count  <= next_fast_low;
         prdata              <= next_prdata;
         pready              <= next_pready;
         pslverr             <= next_pslverr;
         initiator_en        <= next_init_en;
         responder_en        <= next_resp_en;
         restart_allowed     <= next_restart;
         initiator_wide_addr <= next_init_wide;
         responder_wide_addr <= next_resp_wide;
         rate_fast           <= next_rate_fast;
         clk_high_count      <= next_high;
         clk_low_count       <= next_low;
      end
   end

   // checks, all on core_clk with rst_b
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // enables follow control bits two edges after a write
   AST_RESP_EN: assert property (
      clk_en [*3] ##0 ($past(wr, 2) && $past(paddr, 2) == `ICC_OFS_CTRL)
      |-> responder_en == !$past(pwdata[`ICC_BIT_RESP_DIS], 2))
      else $error("responder enable does not follow bit 6");
   // both roles on only when the stored word asked for both; hardware does not refuse it
   AST_BOTH_ROLES: assert property (
      $past(clk_en) |-> (initiator_en && responder_en) ==
         ($past(bus_control_config[`ICC_BIT_INIT_EN]) &&
          !$past(bus_control_config[`ICC_BIT_RESP_DIS])))
      else $error("both roles state does not follow bits 0 and 6");
   AST_RESTART: assert property (clk_en [*2] |-> restart_allowed ==
      $past(bus_control_config[`ICC_BIT_RESTART_EN]))
      else $error("restart permission does not follow bit 5");
   AST_INIT_WIDE: assert property (clk_en [*2] |-> initiator_wide_addr ==
      $past(bus_control_config[`ICC_BIT_INIT_WIDE]))
      else $error("initiator addressing does not follow bit 4");
   AST_RESP_WIDE: assert property (clk_en [*2] |-> responder_wide_addr ==
      $past(bus_control_config[`ICC_BIT_RESP_WIDE]))
      else $error("responder addressing does not follow bit 3");
   // rate and counts are loaded together from the word seen one edge earlier
   AST_RATE_STD: assert property (
      clk_en [*2] ##0 ($past(bus_control_config[`ICC_BIT_RATE_HI:`ICC_BIT_RATE_LO]) == 2'h1)
      |-> !rate_fast && clk_low_count == $past(std_clk_low_count))
      else $error("standard rate not selected for code 1");
   AST_INIT_EN: assert property (clk_en [*2] |-> initiator_en ==
      $past(bus_control_config[`ICC_BIT_INIT_EN]))
      else $error("initiator enable does not follow bit 0");
   // status read lets software see that both roles ended up on
   AST_ADVICE: assert property (
      pready && $past(clk_en) && !$past(pwrite) && $past(paddr) == `ICC_OFS_CFG_STATUS
      |-> prdata[0] == $past(initiator_en && responder_en))
      else $error("status does not show both roles on");
   AST_COUNT_SEL: assert property (clk_en [*2] |-> clk_high_count ==
      (($past(bus_control_config[`ICC_BIT_RATE_HI:`ICC_BIT_RATE_LO]) == 2'h1) ?
       $past(std_clk_high_count) : $past(fast_clk_high_count)))
      else $error("high count not from the selected rate");
   AST_RESERVED: assert property (bus_control_config[15:7] == 9'h0)
      else $error("reserved control bits set");
   AST_ANSWER: assert property (psel && penable && !pready && clk_en |=> pready)
      else $error("answer not one cycle after access start");
   // a frozen answer may stand, an enabled one never twice
   AST_PULSE: assert property (pready && clk_en |=> !pready)
      else $error("answer stands longer than one cycle");

   COV_WRITE_CTRL: cover property (wr && paddr == `ICC_OFS_CTRL);
   COV_STD_RATE:   cover property (!rate_fast ##1 rate_fast);
   COV_RESPONDER:  cover property (responder_en && !initiator_en);
   COV_UNMAPPED:   cover property (pready && pslverr);
   COV_FROZEN:     cover property (psel && penable && !pready && !clk_en);

endmodule // icc_ctrl

// ===== icc_role_view.sv
// consumer-side model that rebuilds the control word from the role outputs
`timescale 1ns/1ps
module icc_role_view (
   input  wire logic        initiator_en,
   input  wire logic        responder_en,
   input  wire logic        restart_allowed,
   input  wire logic        initiator_wide_addr,
   input  wire logic        responder_wide_addr,
   input  wire logic        rate_fast,
   output logic      [15:0] view
);
   // rebuilt word; the rate bit only tells standard from fast, so codes 0/3 cannot show here
   always_comb begin
      view = 16'h0000;                      // reserved bits stay clear
      view[6] = !responder_en;
      view[5] = restart_allowed;
      view[4] = initiator_wide_addr;
      view[3] = responder_wide_addr;
      view[2:1] = rate_fast ? 2'h2 : 2'h1;
      view[0] = initiator_en;
   end
endmodule // icc_role_view

// ===== test_i2c_control_config.sv
// self-checking bench for the control block, driven over apb
`timescale 1ns/1ps
`include "icc_defines.svh"
module test_i2c_control_config;
   localparam logic [15:0] SH = 16'h0123;  // counts above the defaults, distinct per register
   localparam logic [15:0] SL = 16'h0456;
   localparam logic [15:0] FH = 16'h0078;
   localparam logic [15:0] FL = 16'h009a;
   logic        core_clk, rst_b, clk_en, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        i_en, r_en, rs, iw, rw, rf;  // role outputs
   logic [15:0] hc, lc, view;
   int          errors, n_tests;
   // control words kept to the software advice: responder on only with initiator off
   logic [31:0] wtab [4] = '{32'hffff_ffc3, 32'h0000_003c, 32'h0000_0065, 32'h0000_0053};
   logic [31:0] atab [4] = '{`ICC_OFS_STD_HIGH, `ICC_OFS_STD_LOW, `ICC_OFS_FAST_HIGH,
                             `ICC_OFS_FAST_LOW};
   logic [15:0] vtab [4] = '{SH, SL, FH, FL};

   icc_ctrl #(.STD_HIGH_RESET(SH), .STD_LOW_RESET(SL), .FAST_HIGH_RESET(FH),
              .FAST_LOW_RESET(FL)) dut_u (
      .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .initiator_en(i_en), .responder_en(r_en), .restart_allowed(rs),
      .initiator_wide_addr(iw), .responder_wide_addr(rw), .rate_fast(rf),
      .clk_high_count(hc), .clk_low_count(lc));

   icc_role_view view_u (
      .initiator_en(i_en), .responder_en(r_en), .restart_allowed(rs),
      .initiator_wide_addr(iw), .responder_wide_addr(rw), .rate_fast(rf), .view(view));

   // 40 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // one apb transfer; holds the request until pready is sampled, then idles one edge
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);  // only the watchdog ends a dead wait
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);  // gap edge so psel is never driven twice in one step
   endtask

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
         errors++;
      end
   endtask

   // verdict and end of run
   task automatic results();
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      errors = 0;
      n_tests = 0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      chk({16'h0000, view}, 32'h0000_007d, "reset roles");
      chk({16'h0000, hc}, {16'h0000, FH}, "reset high count");
      apb(1'b0, `ICC_OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_007d, "reset ctrl read");
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, atab[i], 32'h0);
         chk(rd, {16'h0000, vtab[i]}, "count reset");
      end
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `ICC_OFS_CTRL, wtab[i]);
         @(posedge core_clk);  // roles and counts follow the stored word one edge later
         chk({16'h0000, view}, wtab[i] & 32'h0000_007f, "role outputs");
         chk({16'h0000, lc}, {16'h0000, (wtab[i][2:1] == 2'h1) ? SL : FL}, "low count");
         chk({16'h0000, hc}, {16'h0000, (wtab[i][2:1] == 2'h1) ? SH : FH}, "high count");
         apb(1'b0, `ICC_OFS_CTRL, 32'h0);
         chk(rd, wtab[i] & 32'h0000_007f, "ctrl readback");
      end
      $display("test table done");
      apb(1'b1, 32'h5000_1304, 32'hffff_ffff);
      chk({31'h0, err}, 32'h1, "unmapped write error");
      apb(1'b0, 32'h5000_1304, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
      apb(1'b1, `ICC_OFS_CFG_STATUS, 32'hffff_ffff);
      chk({31'h0, err}, 32'h0, "status write error");
      apb(1'b0, `ICC_OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_0053, "ctrl kept");
      apb(1'b0, `ICC_OFS_CFG_STATUS, 32'h0);
      chk(rd, 32'h0000_0002, "status one role, legal rate");
      $display("test unmapped done");
      // clk_en low through the access phase: answer and write wait for it
      clk_en <= 1'b0;
      fork
         apb(1'b1, `ICC_OFS_CTRL, 32'h0000_0057);
         begin
            repeat (3) @(posedge core_clk);
            chk({31'h0, pready}, 32'h0, "answer while frozen");
            chk({16'h0000, view}, 32'h0000_0053, "roles while frozen");
            clk_en <= 1'b1;
         end
      join
      @(posedge core_clk);
      chk({16'h0000, view}, 32'h0000_0055, "code 3 falls back to fast");
      chk({16'h0000, lc}, {16'h0000, FL}, "fallback low count");
      apb(1'b0, `ICC_OFS_CFG_STATUS, 32'h0);
      chk(rd, 32'h0000_0000, "status rate code illegal");
      $display("test freeze done");
      // second reset in mid-run brings back the reset word
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      chk({16'h0000, view}, 32'h0000_007d, "roles after reset");
      apb(1'b0, `ICC_OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_007d, "ctrl after reset");
      $display("test second reset done");
      results();
   end

   // watchdog, far beyond the hundred-odd cycles the tests take
   initial begin
      repeat (3000) @(posedge core_clk);
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      results();
   end
endmodule // test_i2c_control_config
